// file: spc_far_master.sv
/*
 far side spi master model that drives the unit in slave role.
 assumes its tasks are called right after a rising pclk edge.
*/
`timescale 1ns/100ps
module spc_far_master
#(
	parameter int HALF = 10
)
(
	input  wire logic pclk,
	output logic      sck,
	output logic      ss_n,
	output logic      mosi,
	input  wire logic miso
);
	initial
	begin
		sck  = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b1;
	end
	// level at select fall picks normal or expander frame
	task automatic start(input logic lvl);
	begin
		mosi <= lvl;
		@(posedge pclk);
		ss_n <= 1'b0;
		repeat (HALF) @(posedge pclk);
	end
	endtask : start
	task automatic xfer(input logic ce, input logic [7:0] b, output logic [7:0] r);
	begin
		for (int i = 7; i >= 0; i--)
		begin
			if (!ce)
				mosi <= b[i];
			repeat (HALF) @(posedge pclk);
			sck <= 1'b1;
			if (ce)
				mosi <= b[i];
			else
				r[i] = miso;
			repeat (HALF) @(posedge pclk);
			sck <= 1'b0;
			if (ce)
				r[i] = miso;
		end
	end
	endtask : xfer
	task automatic stop;
	begin
		repeat (HALF) @(posedge pclk);
		ss_n <= 1'b1;
		// released line must not keep its last level
		mosi <= ~mosi;
		repeat (HALF) @(posedge pclk);
	end
	endtask : stop
endmodule : spc_far_master

// file: spc_params.svh
/*
 holds the offsets, field positions, reset values and rate counts of the spi unit.
 assumes it is included by its bare name from the design file or the bench.
*/
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
`define SPC_IDX_CTRL   10'h098
`define SPC_IDX_STAT   10'h099
`define SPC_IDX_TXD    10'h09a
`define SPC_IDX_RXD    10'h09b
`define SPC_IDX_NXSEL  10'h09c
`define SPC_IDX_IRQST  10'h09d
`define SPC_IDX_IRQMSK 10'h09e
`define SPC_CTRL_RST   8'h00
`define SPC_NXSEL_RST  8'h00
`define SPC_ESS_IDLE   8'hff
`define SPC_TX_FILL    8'hff
`define SPC_B_LOOP     0
`define SPC_B_EN       1
`define SPC_B_SCE      2
`define SPC_B_MODE     3
`define SPC_B_SESS     5
`define SPC_B_TIE      6
`define SPC_B_RIE      7
`define SPC_S_DET      2
`define SPC_S_TXE      4
`define SPC_S_TXF      5
`define SPC_S_RXNE     6
`define SPC_S_ORN      7
`define SPC_I_RX       0
`define SPC_I_TX       1
`define SPC_I_ORN      2
`define SPC_I_DET      3
`define SPC_FIFO_DEPTH 12
`define SPC_DIV1       10
`define SPC_DIV2       40
`define SPC_DIV3       160
`endif

// file: spc_pkg.sv
/*
 holds the types shared by the spi unit.
 assumes spc_params.svh is on the include path.
*/
package spc_pkg;
	typedef enum logic [1:0]
	{
		SPC_IDLE  = 2'b00,
		SPC_LEAD  = 2'b01,
		SPC_RUN   = 2'b11,
		SPC_TRAIL = 2'b10
	} spc_mst_type;
endpackage : spc_pkg

// file: spc_spi_unit.sv
/*
 spi master/slave unit with loop back, select expander, fifos and apb registers.
 assumes pclk is the input clock the master rate is divided from, pins come from
 outside the clock domain, and gp_data comes from port logic on pclk.
*/
`timescale 1ns/100ps
`include "spc_params.svh"
// What this block does
// - With loop back set, transmit bytes pass through the shift register into the receive fifo.
// - In loop back the serial data input is tied to the unit's own data output in either role.
// - Control bit 7 lets the receive interrupt through when set and blocks it when clear.
// - Control bit 6 lets the transmit interrupt through when set and blocks it when clear.
// - With the expander disabled the data line at the select falling edge is ignored.
// - Expander enabled and data low at select fall makes the first byte drive the port.
// - In an expander frame every byte after the first is thrown away.
// - When the select line rises the expander port bits return to one.
// - Mode zero is slave: clock and select are inputs and the slave data output is driven.
// - Other modes are master, driving clock, data and select at input clock over 10, 40 or 160.
// - Edge bit clear launches on falling and samples on rising, set does the reverse.
// - The enable bit activates the pins and sets all expander outputs to one.
// - Each port bit is expander output or general purpose according to its select bit.
// - Twelve byte receive and transmit fifos carry a frame, shifted eight bits at a time.
// - A detect flag is set when the port is programmed and cleared when select rises.
module spc_spi_unit
#(
	parameter int DEPTH = `SPC_FIFO_DEPTH
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_n,
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe_n,
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe_n,
	input  wire logic        ss_in_n,
	output logic             ss_out_n,
	output logic             ss_oe_n,
	input  wire logic [7:0]  gp_data,
	output logic      [7:0]  port_out,
	output logic             irq
);
	import spc_pkg::*;
	default clocking spc_cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [6:0] HALF1 = 7'(`SPC_DIV1 / 2);
	localparam logic [6:0] HALF2 = 7'(`SPC_DIV2 / 2);
	localparam logic [6:0] HALF3 = 7'(`SPC_DIV3 / 2);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	typedef struct packed {
		logic [7:0]            ctrl;
		logic [7:0]            nxsel;
		logic [3:0]            irqst;
		logic [3:0]            irqmsk;
		logic [3:0][2:0]       sy;
		logic [3:0]            flt;
		spc_mst_type           mst;
		logic [6:0]            divcnt;
		logic                  sck_o;
		logic                  ss_o;
		logic                  dout;
		logic [7:0]            txsh;
		logic [7:0]            rxsh;
		logic [7:0]            txhold;
		logic [2:0]            bitcnt;
		logic                  loaded;
		logic                  expmode;
		logic                  expdone;
		logic [7:0]            expanded_select_lines;
		logic                  det;
		logic                  en_d;
		logic [DEPTH-1:0][7:0] txmem;
		logic [AW-1:0]         txwp;
		logic [AW-1:0]         txrp;
		logic [CW-1:0]         txcnt;
		logic [DEPTH-1:0][7:0] rxmem;
		logic [AW-1:0]         rxwp;
		logic [AW-1:0]         rxrp;
		logic [CW-1:0]         rxcnt;
		logic [31:0]           prdata;
		logic                  pready;
		logic                  pslverr;
		logic [3:0]            oe_n;
		logic [7:0]            port_out;
		logic                  irq;
	} spc_state_type;
	spc_state_type s;
	spc_state_type n;
	logic [9:0]    idx;
	logic          acc;
	logic [3:0]    pins;
	logic          master;
	logic          en;
	logic          clock_edge_select;
	logic          rise;
	logic          fall;
	logic          start;
	logic          stop;
	logic          launch;
	logic          sample;
	logic          din;
	logic          active;
	logic          pop;
	logic          push;
	logic          byte_done;
	logic [7:0]    rxb;
	logic [7:0]    ldb;
	logic          ss_fall;
	logic          ss_rise;
	logic [3:0]    ev;
	logic [3:0]    gate;
	logic [6:0]    half;
	logic          tx_wr;
	logic          rx_rd;
	function automatic logic [AW-1:0] spc_inc(input logic [AW-1:0] p);
		spc_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : spc_inc
	assign pins = {ss_in_n, miso_in, mosi_in, sck_in};
	always_comb
	begin
		n = s;
		idx = paddr[11:2];
		acc = psel & penable & s.pready & ~s.pslverr;
		en = s.ctrl[`SPC_B_EN];
		master = s.ctrl[`SPC_B_MODE+1 -: 2] != 2'b00;
		clock_edge_select = s.ctrl[`SPC_B_SCE];
		rise = 1'b0;
		fall = 1'b0;
		start = 1'b0;
		stop = 1'b0;
		pop = 1'b0;
		push = 1'b0;
		byte_done = 1'b0;
		ev = 4'h0;
		ldb = `SPC_TX_FILL;
		// filtered value moves only once stages two and three agree
		for (int k = 0; k < 4; k++)
		begin
			n.sy[k] = {s.sy[k][1:0], pins[k]};
			if (s.sy[k][1] == s.sy[k][2])
				n.flt[k] = s.sy[k][2];
		end
		ss_fall = s.flt[3] & ~n.flt[3];
		ss_rise = ~s.flt[3] & n.flt[3];
		unique case (s.ctrl[`SPC_B_MODE+1 -: 2])
			2'b01: half = HALF1;
			2'b10: half = HALF2;
			default: half = HALF3;
		endcase
		if (en && master)
		begin
			unique case (s.mst)
				SPC_IDLE:
					if (s.txcnt != '0)
					begin
						n.ss_o = 1'b0;
						n.mst = SPC_LEAD;
						n.divcnt = '0;
						start = 1'b1;
					end
				SPC_LEAD:
				begin
					n.divcnt = 7'(s.divcnt + 1'b1);
					if (s.divcnt == 7'(half - 1'b1))
					begin
						n.divcnt = '0;
						n.mst = SPC_RUN;
						n.sck_o = 1'b1;
						rise = 1'b1;
					end
				end
				SPC_RUN:
				begin
					n.divcnt = 7'(s.divcnt + 1'b1);
					if (s.divcnt == 7'(half - 1'b1))
					begin
						n.divcnt = '0;
						if (s.sck_o)
						begin
							n.sck_o = 1'b0;
							fall = 1'b1;
						end
						else if (!s.loaded && s.bitcnt == 3'd0 && s.txcnt == '0)
							n.mst = SPC_TRAIL;
						else
						begin
							n.sck_o = 1'b1;
							rise = 1'b1;
						end
					end
				end
				SPC_TRAIL:
				begin
					n.divcnt = 7'(s.divcnt + 1'b1);
					if (s.divcnt == 7'(half - 1'b1))
					begin
						n.ss_o = 1'b1;
						n.mst = SPC_IDLE;
						stop = 1'b1;
					end
				end
			endcase
			// first rise of a frame is raised while still in the lead state
			active = s.mst != SPC_IDLE;
		end
		else
		begin
			n.mst = SPC_IDLE;
			n.sck_o = 1'b0;
			n.ss_o = 1'b1;
			n.divcnt = '0;
			// slave takes clock and select from pins
			if (en)
			begin
				rise = ~s.flt[0] & n.flt[0];
				fall = s.flt[0] & ~n.flt[0];
				start = ss_fall;
				stop = ss_rise;
			end
			active = en & ~s.flt[3];
		end
		launch = clock_edge_select ? rise : fall;
		sample = clock_edge_select ? fall : rise;
		din = s.ctrl[`SPC_B_LOOP] ? s.dout : (master ? s.flt[2] : s.flt[1]);
		if (start || stop)
		begin
			n.bitcnt = '0;
			n.loaded = 1'b0;
		end
		if (s.txcnt != '0)
			ldb = s.txmem[s.txrp];
		if (((start && !clock_edge_select) || (launch && !s.loaded && !start)) && (!master || s.txcnt != '0))
		begin
			pop = s.txcnt != '0;
			n.txhold = ldb;
			n.dout = ldb[7];
			n.txsh = {ldb[6:0], 1'b0};
			n.loaded = 1'b1;
		end
		else if (launch && s.loaded)
		begin
			n.dout = s.txsh[7];
			n.txsh = {s.txsh[6:0], 1'b0};
		end
		rxb = {s.rxsh[6:0], din};
		if (sample && active)
		begin
			n.rxsh = rxb;
			n.bitcnt = 3'(s.bitcnt + 1'b1);
			if (s.bitcnt == 3'd7)
			begin
				byte_done = 1'b1;
				n.loaded = 1'b0;
			end
		end
		if (ss_rise || !en || (en && !s.en_d))
		begin
			n.expmode = 1'b0;
			n.expdone = 1'b0;
			n.expanded_select_lines = `SPC_ESS_IDLE;
			n.det = 1'b0;
		end
		n.en_d = en;
		if (en && !master && ss_fall && s.ctrl[`SPC_B_SESS] && !s.flt[1])
			n.expmode = 1'b1;
		if (byte_done)
		begin
			if (s.expmode)
			begin
				if (!s.expdone)
				begin
					n.expanded_select_lines = rxb;
					n.expdone = 1'b1;
					n.det = 1'b1;
					ev[`SPC_I_DET] = 1'b1;
				end
			end
			else
				push = 1'b1;
		end
		tx_wr = acc & pwrite & (idx == `SPC_IDX_TXD) & (s.txcnt != FULL);
		rx_rd = acc & ~pwrite & (idx == `SPC_IDX_RXD) & (s.rxcnt != '0);
		if (tx_wr)
		begin
			n.txmem[s.txwp] = pwdata[7:0];
			n.txwp = spc_inc(s.txwp);
		end
		if (pop)
			n.txrp = spc_inc(s.txrp);
		n.txcnt = CW'(s.txcnt + tx_wr - pop);
		ev[`SPC_I_TX] = pop & (s.txcnt == CW'(1)) & ~tx_wr;
		if (push && s.rxcnt == FULL && !rx_rd)
			ev[`SPC_I_ORN] = 1'b1;
		else if (push)
		begin
			n.rxmem[s.rxwp] = rxb;
			n.rxwp = spc_inc(s.rxwp);
			ev[`SPC_I_RX] = 1'b1;
		end
		if (rx_rd)
			n.rxrp = spc_inc(s.rxrp);
		n.rxcnt = CW'(s.rxcnt + (push & ~ev[`SPC_I_ORN]) - rx_rd);
		if (acc && pwrite)
		begin
			if (idx == `SPC_IDX_CTRL)
				n.ctrl = pwdata[7:0];
			if (idx == `SPC_IDX_NXSEL)
				n.nxsel = pwdata[7:0];
			if (idx == `SPC_IDX_IRQMSK)
				n.irqmsk = pwdata[3:0];
			if (idx == `SPC_IDX_IRQST)
				n.irqst = s.irqst & ~pwdata[3:0];
		end
		// set wins over a clear in the same cycle
		n.irqst = n.irqst | ev;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.prdata = '0;
		if (psel && !penable)
		begin
			n.pready = 1'b1;
			n.pslverr = paddr[1:0] != 2'b00;
			unique case (idx)
				`SPC_IDX_CTRL: n.prdata[7:0] = s.ctrl;
				`SPC_IDX_STAT: n.prdata[7:0] = {s.irqst[`SPC_I_ORN], s.rxcnt != '0,
					s.txcnt == FULL, s.txcnt == '0, 1'b0, s.det, 2'b00};
				`SPC_IDX_TXD: n.prdata = '0;
				`SPC_IDX_RXD: n.prdata[7:0] = s.rxmem[s.rxrp];
				`SPC_IDX_NXSEL: n.prdata[7:0] = s.nxsel;
				`SPC_IDX_IRQST: n.prdata[3:0] = s.irqst;
				`SPC_IDX_IRQMSK: n.prdata[3:0] = s.irqmsk;
				default: n.pslverr = 1'b1;
			endcase
			if (n.pslverr)
				n.prdata = '0;
		end
		n.oe_n[0] = ~(n.ctrl[`SPC_B_EN] & (n.ctrl[`SPC_B_MODE+1 -: 2] != 2'b00));
		n.oe_n[1] = n.oe_n[0];
		n.oe_n[3] = n.oe_n[0];
		n.oe_n[2] = ~(n.ctrl[`SPC_B_EN] & (n.ctrl[`SPC_B_MODE+1 -: 2] == 2'b00));
		for (int i = 0; i < 8; i++)
			n.port_out[i] = n.nxsel[i] ? n.expanded_select_lines[i] : gp_data[i];
		gate[`SPC_I_RX] = n.ctrl[`SPC_B_RIE];
		gate[`SPC_I_ORN] = n.ctrl[`SPC_B_RIE];
		gate[`SPC_I_DET] = n.ctrl[`SPC_B_RIE];
		gate[`SPC_I_TX] = n.ctrl[`SPC_B_TIE];
		n.irq = |(n.irqst & n.irqmsk & gate);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.ctrl <= `SPC_CTRL_RST;
			s.nxsel <= `SPC_NXSEL_RST;
			s.sy[3] <= 3'h7;
			s.flt[3] <= 1'b1;
			s.ss_o <= 1'b1;
			s.expanded_select_lines <= `SPC_ESS_IDLE;
			s.oe_n <= 4'hf;
			s.mst <= SPC_IDLE;
		end
		else
			s <= n;
	end
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign sck_out = s.sck_o;
	assign sck_oe_n = s.oe_n[0];
	assign mosi_out = s.dout;
	assign mosi_oe_n = s.oe_n[1];
	assign miso_out = s.dout;
	assign miso_oe_n = s.oe_n[2];
	assign ss_out_n = s.ss_o;
	assign ss_oe_n = s.oe_n[3];
	assign port_out = s.port_out;
	assign irq = s.irq;
	AST_LOOP_DATA: assert property (push && s.ctrl[`SPC_B_LOOP] && master |-> rxb == s.txhold)
		else $error("loop back byte differs from sent byte");
	AST_LOOP_TIE: assert property (sample && active && s.ctrl[`SPC_B_LOOP] |-> ##1 s.rxsh[0] == $past(s.dout))
		else $error("loop back input not tied to output");
	AST_RX_GATE: assert property (!s.ctrl[`SPC_B_RIE] && !s.ctrl[`SPC_B_TIE] |-> !irq)
		else $error("receive interrupt not gated");
	AST_TX_GATE: assert property (s.ctrl[`SPC_B_TIE] && s.irqst[`SPC_I_TX] && s.irqmsk[`SPC_I_TX] |-> irq)
		else $error("transmit interrupt missing");
	AST_NO_EXP: assert property (ss_fall && !s.ctrl[`SPC_B_SESS] && !s.expmode |=> !s.expmode)
		else $error("expander entered while disabled");
	AST_EXP_ENTER: assert property (en && !master && ss_fall && s.ctrl[`SPC_B_SESS] && !s.flt[1] |=> s.expmode)
		else $error("expander not entered");
	AST_DISCARD: assert property (s.expmode && s.expdone |-> !push ##1 s.expanded_select_lines == $past(s.expanded_select_lines) || !s.expdone)
		else $error("byte after the first not discarded");
	AST_RELEASE: assert property (ss_rise |=> s.expanded_select_lines == `SPC_ESS_IDLE ##1 port_out == (s.nxsel & `SPC_ESS_IDLE | ~s.nxsel & $past(gp_data)))
		else $error("expander outputs not released");
	AST_SLAVE_PINS: assert property (en && !master && $stable(s.ctrl) |-> sck_oe_n && ss_oe_n && !miso_oe_n && mosi_oe_n)
		else $error("slave pin directions wrong");
	AST_DIV1: assert property ($rose(sck_out) && s.ctrl[`SPC_B_MODE+1 -: 2] == 2'b01 && $stable(s.ctrl) |-> $past(sck_out, 5) == 1'b0 ##5 !sck_out)
		else $error("master clock rate wrong");
	AST_EDGE: assert property (master && !clock_edge_select && s.mst == SPC_RUN && $changed(s.dout) |-> $fell(sck_out))
		else $error("data launched on wrong edge");
	AST_ENABLE: assert property ($rose(en) |=> s.expanded_select_lines == `SPC_ESS_IDLE)
		else $error("expander outputs not set on enable");
	AST_FIFO: assert property (s.txcnt <= FULL && s.rxcnt <= FULL)
		else $error("fifo count beyond depth");
	AST_DET_CLR: assert property (ss_rise |=> !s.det)
		else $error("detect flag not cleared");
	COV_MASTER: cover property (master && byte_done);
	COV_EXP: cover property (s.expmode && byte_done ##[1:400] ss_rise);
	COV_LOOP: cover property (s.ctrl[`SPC_B_LOOP] && push);
	COV_ORN: cover property (ev[`SPC_I_ORN]);
endmodule : spc_spi_unit

// file: tb_top.sv
/*
 self-checking bench of the spi unit: apb master, far master model, loop back.
 assumes the unit answers apb through pready and pins settle within a few cycles.
*/
`timescale 1ns/100ps
`include "spc_params.svh"
module tb_top;
	import spc_pkg::*;
	localparam logic [11:0] A_CTRL  = {`SPC_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_STAT  = {`SPC_IDX_STAT, 2'b00};
	localparam logic [11:0] A_TXD   = {`SPC_IDX_TXD, 2'b00};
	localparam logic [11:0] A_RXD   = {`SPC_IDX_RXD, 2'b00};
	localparam logic [11:0] A_NXSEL = {`SPC_IDX_NXSEL, 2'b00};
	localparam logic [11:0] A_IRQST = {`SPC_IDX_IRQST, 2'b00};
	localparam logic [11:0] A_IRQM  = {`SPC_IDX_IRQMSK, 2'b00};
	localparam int          LIMIT   = 20000;
	localparam int          DIVS[3] = '{`SPC_DIV1, `SPC_DIV2, `SPC_DIV3};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
	logic        ss_out_n, ss_oe_n, m_sck, m_ss_n, m_mosi, e, sck_q;
	logic [7:0]  gp_data, port_out, b, nx, r8;
	logic [7:0]  txq[$], rxq[$];
	int          error_cnt, total_checks, cyc, last_rise, sck_per, c;
	wire         sck_w  = sck_oe_n ? m_sck : sck_out;
	wire         ss_w   = ss_oe_n ? m_ss_n : ss_out_n;
	wire         mosi_w = mosi_oe_n ? m_mosi : mosi_out;
	// undriven data line shows an inverse pattern
	wire         miso_w = miso_oe_n ? ~mosi_w : miso_out;
	spc_spi_unit DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sck_in(sck_w), .sck_out(sck_out),
		.sck_oe_n(sck_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out),
		.mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out),
		.miso_oe_n(miso_oe_n), .ss_in_n(ss_w), .ss_out_n(ss_out_n), .ss_oe_n(ss_oe_n),
		.gp_data(gp_data), .port_out(port_out), .irq(irq));
	spc_far_master u_far (.pclk(pclk), .sck(m_sck), .ss_n(m_ss_n), .mosi(m_mosi),
		.miso(miso_w));
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc++;
		if (sck_out === 1'b1 && sck_q === 1'b0)
		begin
			sck_per = cyc - last_rise;
			last_rise = cyc;
		end
		sck_q = sck_out;
		if (cyc == LIMIT)
		begin
			error_cnt++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	begin
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask : chk
	task automatic test_done;
	begin
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask : test_done
	// one idle cycle after each transfer keeps psel single-driven per step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
	begin
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	end
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
	begin
		apb(1'b1, a, d, r, e);
	end
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
	begin
		apb(1'b0, a, 32'h0, r, e);
		chk(r & m, x);
	end
	endtask : rdc
	// a select that never moves ends the run through the cycle ceiling
	task automatic wait_ss(input logic v);
	begin
		while (ss_out_n !== v)
		begin
			@(posedge pclk);
		end
	end
	endtask : wait_ss
	initial
	begin
		void'($urandom(67));
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		gp_data = 8'($urandom());
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(A_CTRL, 32'hffffffff, 32'h0);
		rdc(A_NXSEL, 32'hffffffff, 32'h0);
		apb(1'b1, 12'h004, 32'h1, r, e);
		chk(32'(e), 32'h1);
		wr(A_IRQM, 32'h3);
		for (int i = 0; i < 3; i++)
		begin
			b = 8'($urandom());
			c = 3 + (i + 1) * 8 + (i % 2) * 4 + (i == 1) * 128 + (i == 2) * 64;
			wr(A_CTRL, 32'(c));
			wr(A_TXD, {24'h0, b});
			wait_ss(1'b0);
			chk(32'({sck_oe_n, ss_oe_n, mosi_oe_n, miso_oe_n}), 32'h1);
			wait_ss(1'b1);
			chk(32'(sck_per), DIVS[i]);
			chk(32'(irq), 32'(i != 0));
			rdc(A_IRQST, 32'hf, 32'h3);
			wr(A_IRQST, 32'h3);
			@(posedge pclk);
			chk(32'(irq), 32'h0);
			rdc(A_RXD, 32'hff, {24'h0, b});
		end
		wr(A_CTRL, 32'h0);
		for (int k = 0; k < 13; k++)
		begin
			b = 8'($urandom());
			wr(A_TXD, {24'h0, b});
			if (k < 12)
				txq.push_back(b);
		end
		rdc(A_STAT, 32'hfc, 32'h20);
		wr(A_CTRL, 32'h06);
		chk(32'({sck_oe_n, ss_oe_n, mosi_oe_n, miso_oe_n}), 32'he);
		u_far.start(1'b1);
		for (int k = 0; k < 12; k++)
		begin
			b = 8'($urandom());
			u_far.xfer(1'b1, b, r8);
			chk({24'h0, r8}, {24'h0, txq.pop_front()});
			rxq.push_back(b);
		end
		u_far.stop();
		for (int k = 0; k < 12; k++)
			rdc(A_RXD, 32'hff, {24'h0, rxq.pop_front()});
		nx = 8'($urandom());
		b = 8'($urandom());
		wr(A_NXSEL, {24'h0, nx});
		wr(A_CTRL, 32'h02);
		u_far.start(1'b0);
		u_far.xfer(1'b0, b, r8);
		u_far.stop();
		chk(32'(port_out), 32'(nx | gp_data));
		rdc(A_RXD, 32'hff, {24'h0, b});
		wr(A_CTRL, 32'h22);
		u_far.start(1'b0);
		u_far.xfer(1'b0, b, r8);
		chk(32'(port_out), 32'((b & nx) | (gp_data & ~nx)));
		rdc(A_STAT, 32'h04, 32'h04);
		u_far.xfer(1'b0, ~b, r8);
		chk(32'(port_out), 32'((b & nx) | (gp_data & ~nx)));
		u_far.stop();
		chk(32'(port_out), 32'(nx | gp_data));
		rdc(A_STAT, 32'h44, 32'h00);
		test_done();
	end
endmodule : tb_top
